/* design/mode_set_mem.sv */
// Memory end: mode register storage, update delay and burst beat ordering
`timescale 1ns/10ps
`include "mode_set_regs.svh"

module mode_set_mem #(
  parameter int COLS = 1024
) (
  // Clock and reset
  input  wire logic    clk,
  input  wire logic    rst,
  // Link
  mode_set_if.mem      link,
  // User side
  output logic [17:0]  base_mode_register,
  output logic         settings_ready,
  output logic         dll_reset_pulse,
  output logic [9:0]   col_addr,
  output logic         col_write,
  output logic [7:0]   col_wdata
);

  initial
  begin
    if (COLS < 8 || COLS > 1024 || (COLS % 8) != 0)
      $error("COLS must be a multiple of 8 up to 1024");
  end

  typedef struct packed {
    logic [17:0] mr0;
    logic [17:0] mr2;
    logic [3:0]  mod_cnt;
    logic        busy;
    logic        dll_rst;
    logic        active;
    logic        is_write;
    logic        chop;
    logic        itl;
    logic [2:0]  start;
    logic [6:0]  block;
    logic [2:0]  beat;
    logic [7:0]  rdata;
    logic        rvalid;
    logic        rdrive;
    logic [2:0]  rcol;
    logic [9:0]  col_addr;
    logic        col_write;
    logic [7:0]  col_wdata;
  } mem_state_s;

  mem_state_s st;
  mem_state_s next_st;

  // Small storage of one burst block row; array content is never touched by mode set
  logic [7:0] store [0:COLS-1];
  logic [2:0] col_lo;

  always_comb
  begin
    next_st = st;
    next_st.dll_rst = 1'b0;
    next_st.col_write = 1'b0;
    next_st.rvalid = 1'b0;
    col_lo = 3'h0;
    if (st.busy)
    begin
      // New features counted unavailable until the update delay expires
      if (st.mod_cnt == 4'h0)
        next_st.busy = 1'b0;
      else
        next_st.mod_cnt = st.mod_cnt - 4'h1;
    end
    if (link.cmd == mode_set_pkg::cmd_mrs)
    begin
      if (link.bank == `BANK_SEL_MR0)
      begin
        // Whole value replaced; DLL reset bit never stored
        next_st.mr0 = link.addr;
        next_st.mr0[`BMR_DLL_RST_BIT] = 1'b0;
        next_st.dll_rst = link.addr[`BMR_DLL_RST_BIT];
      end
      else if (link.bank == `BANK_SEL_MR2)
        next_st.mr2 = link.addr;
      next_st.busy = 1'b1;
      next_st.mod_cnt = 4'(`MOD_CYCLES - 1);
    end
    if (st.active)
    begin
      // Read order within nibble: sequential adds mod 4, interleaved xors; writes go in beat order
      if (st.is_write)
        col_lo = st.chop ? {st.start[2], st.beat[1:0]} : st.beat;
      else if (st.itl)
        col_lo = st.start ^ st.beat;
      else
        col_lo = {st.start[2] ^ st.beat[2], st.start[1:0] + st.beat[1:0]};
      if (st.chop && st.beat[2])
      begin
        // Last four slots: drivers off for reads, data ignored for writes
        next_st.rdrive = 1'b0;
      end
      else if (st.is_write)
      begin
        next_st.col_write = link.wvalid;
        next_st.col_addr = {st.block, col_lo};
        next_st.col_wdata = link.wdata;
      end
      else
      begin
        next_st.rvalid = 1'b1;
        next_st.rdrive = 1'b1;
        next_st.rcol = col_lo;
        next_st.rdata = store[{st.block, col_lo}];
      end
      next_st.beat = st.beat + 3'h1;
      if (st.beat == 3'(`BURST_SLOTS - 1))
        next_st.active = 1'b0;
    end
    else
      next_st.rdrive = 1'b0;
    if (link.cmd == mode_set_pkg::cmd_read || link.cmd == mode_set_pkg::cmd_write)
    begin
      // Same length decode for both directions; reads start at the given slot, writes at slot 0 of its nibble for chop and at slot 0 for eight beats
      next_st.active = 1'b1;
      next_st.is_write = (link.cmd == mode_set_pkg::cmd_write);
      next_st.itl = st.mr0[`BMR_BT_BIT];
      if (st.mr0[`BMR_BL_MSB:`BMR_BL_LSB] == `BL_CODE_OTF)
        next_st.chop = ~link.addr[12];
      else
        next_st.chop = (st.mr0[`BMR_BL_MSB:`BMR_BL_LSB] == `BL_CODE_CHOP4);
      next_st.start = link.addr[2:0];
      next_st.block = link.addr[9:3];
      next_st.beat = 3'h0;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st <= '0;
      st.mr0 <= `BMR_RESET_VALUE;
    end
    else
      st <= next_st;
  end

  always_ff @(posedge clk)
  begin
    if (st.col_write)
      store[st.col_addr] <= st.col_wdata;
  end

  assign link.rdata  = st.rdata;
  assign link.rvalid = st.rvalid;
  assign link.rdrive = st.rdrive;
  assign link.rcol   = st.rcol;

  assign base_mode_register = st.mr0;
  assign settings_ready     = ~st.busy;
  assign dll_reset_pulse    = st.dll_rst;
  assign col_addr           = st.col_addr;
  assign col_write          = st.col_write;
  assign col_wdata          = st.col_wdata;

endmodule

/* design/mode_set_regs.svh */
// Offsets, field positions, reset values and timing counts of the mode-set link
`ifndef MODE_SET_REGS_SVH
`define MODE_SET_REGS_SVH

// Base mode register fields
`define BMR_BL_LSB        0
`define BMR_BL_MSB        1
`define BMR_BT_BIT        3
`define BMR_DLL_RST_BIT   8
`define BMR_RESET_VALUE   18'h00000
`define BMR_RSVD_MASK     18'h26080

// Burst length field codes
`define BL_CODE_FIXED8    2'h0
`define BL_CODE_OTF       2'h1
`define BL_CODE_CHOP4     2'h2

// Register select on bank bits
`define BANK_SEL_MR0      3'h0
`define BANK_SEL_MR2      3'h2

// Timing counts in clock cycles
`define MRD_CYCLES        4
`define MOD_CYCLES        12
`define MRSPDEN_CYCLES    12
`define XPDLL_CYCLES      10
`define DLLK_CYCLES       512
`define BURST_SLOTS       8

`endif

/* design/mode_set_pkg.sv */
// Types shared by both ends of the mode-set link
package mode_set_pkg;

  typedef enum logic [2:0] {
    cmd_nop,
    cmd_mrs,
    cmd_read,
    cmd_write,
    cmd_pdn,
    cmd_long_impedance_calibration
  } cmd_e;

  typedef enum logic [1:0] {
    bt_seq,
    bt_int
  } burst_type_e;

endpackage

/* design/mode_set_if.sv */
// Command and data link between the controller end and the memory end
`timescale 1ns/10ps
interface mode_set_if;
  mode_set_pkg::cmd_e cmd;
  logic [2:0]         bank;
  logic [17:0]        addr;
  logic               cke;
  logic               odt;
  logic [7:0]         wdata;
  logic               wvalid;
  logic [7:0]         rdata;
  logic               rvalid;
  logic               rdrive;
  logic [2:0]         rcol;

  modport host (
    output cmd, bank, addr, cke, odt, wdata, wvalid,
    input  rdata, rvalid, rdrive, rcol
  );

  modport mem (
    input  cmd, bank, addr, cke, odt, wdata, wvalid,
    output rdata, rvalid, rdrive, rcol
  );
endinterface

/* design/mode_set_host.sv */
// Controller end: spaces mode sets, holds clock enable and termination
`timescale 1ns/10ps
`include "mode_set_regs.svh"
module mode_set_host (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // User request
  input  wire logic        req_valid,
  input  mode_set_pkg::cmd_e req_cmd,
  input  wire logic [2:0]  req_bank,
  input  wire logic [17:0] req_addr,
  input  wire logic [7:0]  req_wdata,
  input  wire logic        banks_idle,
  input  wire logic        odt_want,
  output logic             req_ready,
  // Link
  mode_set_if.host         link
);

  typedef enum logic [1:0] { s_run, s_zq_wait } host_state_e;

  typedef struct packed {
    host_state_e st;
    logic [9:0]  mrd_cnt;
    logic [9:0]  mod_cnt;
    logic [9:0]  pd_cnt;
    logic [9:0]  xp_cnt;
    logic [9:0]  dllk_cnt;
    logic [3:0]  wbeat;
    mode_set_pkg::cmd_e cmd;
    logic [2:0]  bank;
    logic [17:0] addr;
    logic        cke;
    logic        odt;
    logic [7:0]  wdata;
    logic        wvalid;
    logic [2:0]  cl;
  } host_state_s;

  host_state_s s;
  host_state_s next_s;
  logic        ok;

  always_comb
  begin
    next_s = s;
    next_s.cmd = mode_set_pkg::cmd_nop;
    next_s.wvalid = 1'b0;
    ok = 1'b0;
    if (s.mrd_cnt != 10'h0) next_s.mrd_cnt = s.mrd_cnt - 10'h1;
    if (s.mod_cnt != 10'h0) next_s.mod_cnt = s.mod_cnt - 10'h1;
    if (s.pd_cnt != 10'h0) next_s.pd_cnt = s.pd_cnt - 10'h1;
    if (s.xp_cnt != 10'h0) next_s.xp_cnt = s.xp_cnt - 10'h1;
    if (s.dllk_cnt != 10'h0) next_s.dllk_cnt = s.dllk_cnt - 10'h1;
    if (s.wbeat != 4'h0)
    begin
      next_s.wbeat = s.wbeat - 4'h1;
      next_s.wvalid = 1'b1;
      next_s.wdata = s.wdata + 8'h01;
    end
    // Termination low through whole update window
    next_s.odt = odt_want && (s.mod_cnt == 10'h0);
    next_s.cke = 1'b1;
    if (req_valid && s.wbeat == 4'h0)
    begin
      case (req_cmd)
        mode_set_pkg::cmd_mrs:
          ok = banks_idle && s.mrd_cnt == 10'h0;
        mode_set_pkg::cmd_pdn:
          ok = s.pd_cnt == 10'h0 && s.mod_cnt == 10'h0;
        mode_set_pkg::cmd_read:
          ok = s.mod_cnt == 10'h0 && s.xp_cnt == 10'h0 && s.dllk_cnt == 10'h0;
        default:
          ok = s.mod_cnt == 10'h0 && s.xp_cnt == 10'h0;
      endcase
      if (s.st == s_zq_wait && req_cmd != mode_set_pkg::cmd_long_impedance_calibration)
        ok = 1'b0;
    end
    if (ok)
    begin
      next_s.cmd = req_cmd;
      next_s.bank = req_bank;
      next_s.addr = req_addr;
      case (req_cmd)
        mode_set_pkg::cmd_mrs:
        begin
          if (req_bank == `BANK_SEL_MR0)
          begin
            next_s.addr = req_addr & ~`BMR_RSVD_MASK;
            if (req_addr[6:4] != s.cl)
              next_s.xp_cnt = 10'(`XPDLL_CYCLES + `MOD_CYCLES);
            next_s.cl = req_addr[6:4];
            if (req_addr[`BMR_DLL_RST_BIT])
              next_s.dllk_cnt = 10'(`DLLK_CYCLES);
          end
          if (req_bank == `BANK_SEL_MR2)
            next_s.st = s_zq_wait;
          next_s.mrd_cnt = 10'(`MRD_CYCLES);
          next_s.mod_cnt = 10'(`MOD_CYCLES);
          next_s.pd_cnt = 10'(`MRSPDEN_CYCLES);
          // Termination must already be low on the edge that carries the mode set
          next_s.odt = 1'b0;
        end
        mode_set_pkg::cmd_long_impedance_calibration:
          next_s.st = s_run;
        mode_set_pkg::cmd_pdn:
          next_s.cke = 1'b0;
        mode_set_pkg::cmd_write:
        begin
          next_s.wbeat = 4'(`BURST_SLOTS);
          next_s.wdata = req_wdata - 8'h01;
        end
        default:
        begin
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      s <= '0;
    else
      s <= next_s;
  end

  assign req_ready   = ok;
  assign link.cmd    = s.cmd;
  assign link.bank   = s.bank;
  assign link.addr   = s.addr;
  assign link.cke    = s.cke;
  assign link.odt    = s.odt;
  assign link.wdata  = s.wdata;
  assign link.wvalid = s.wvalid;

endmodule

/* tb/mode_set_props.sv */
// Link-level timing and beat-order checks for the mode-set link
`timescale 1ns/10ps
`include "mode_set_regs.svh"
module mode_set_props (
  // Clock and reset
  input logic               clk,
  input logic               rst,
  // Link
  input mode_set_pkg::cmd_e cmd,
  input logic [2:0]         bank,
  input logic [17:0]        addr,
  input logic               cke,
  input logic               odt,
  input logic               rvalid,
  input logic               rdrive,
  input logic [2:0]         rcol
);
  logic       mrs, rd, mr0, idle, chop, bt, rt;
  logic [1:0] bl;
  logic [2:0] rs, rb;
  logic [9:0] lock;
  assign mrs  = cmd == mode_set_pkg::cmd_mrs;
  assign rd   = cmd == mode_set_pkg::cmd_read;
  assign mr0  = mrs && bank == `BANK_SEL_MR0;
  assign idle = cmd inside {mode_set_pkg::cmd_nop, mode_set_pkg::cmd_mrs};
  assign chop = bl == `BL_CODE_CHOP4 || (bl == `BL_CODE_OTF && !addr[12]);
  // Shadow of length, type and lock wait as the memory end should hold them
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      {bl, bt, rs, rb, rt} <= 10'h000;
      lock <= 10'h000;
    end
    else
    begin
      if (mr0)
        {bt, bl} <= {addr[3], addr[1:0]};
      if (rd)
        {rt, rs, rb} <= {bt, addr[2:0], 3'h0};
      else if (rvalid)
        rb <= rb + 3'h1;
      if (mr0 && addr[8])
        lock <= 10'h1FF;
      else if (lock != 10'h000)
        lock <= lock - 10'h001;
    end
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  a_mrs_spacing: assert property (mrs |=> !mrs [*3])
    else $error("mode sets too close");
  a_mod_idle: assert property (mrs |=> idle [*8] ##1 idle [*3])
    else $error("command inside update delay");
  a_cke_held: assert property (mrs |-> cke [*8] ##1 cke [*4])
    else $error("clock enable dropped after mode set");
  a_odt_low: assert property (mrs |-> !odt [*8] ##1 !odt [*4])
    else $error("termination high after mode set");
  a_mr2_zq: assert property (mrs && bank == `BANK_SEL_MR2 |=>
    (cmd inside {mode_set_pkg::cmd_nop, mode_set_pkg::cmd_long_impedance_calibration}) [*8])
    else $error("command before calibration");
  a_rsvd_zero: assert property (mr0 |-> (addr & `BMR_RSVD_MASK) == 18'h00000)
    else $error("reserved bits set");
  a_lock_wait: assert property (rd |-> lock == 10'h000)
    else $error("read before lock time");
  a_read_order: assert property (rvalid |-> rcol ==
    (rt ? rs ^ rb : {rs[2] ^ rb[2], rs[1:0] + rb[1:0]}))
    else $error("read beat order wrong");
  a_chop_off: assert property (rd && chop |-> ##2 rvalid [*4] ##1
    (!rdrive && !rvalid) [*4])
    else $error("chop read slots wrong");
  a_eight_beats: assert property (rd && !chop |-> ##2 rvalid [*8])
    else $error("eight-beat read slots wrong");
endmodule

/* tb/testbench.sv */
// Bench joining controller end and memory end across the link
`timescale 1ns/10ps
`include "mode_set_regs.svh"
module testbench;
  logic               clk, rst, req_valid, banks_idle, odt_want, req_ready;
  logic               settings_ready, dll_reset_pulse, col_write;
  mode_set_pkg::cmd_e req_cmd;
  logic [2:0]         req_bank, rq[$];
  logic [17:0]        req_addr, base_mode_register;
  logic [9:0]         col_addr, wq[$];
  logic [7:0]         col_wdata, dq[$];
  int                 err_count, checks_done, dll_seen, t, m, k;
  logic [1:0]         code;
  logic               c4;
  mode_set_if link_if ();
  mode_set_host mode_set_host_inst (.clk(clk), .rst(rst), .req_valid(req_valid),
    .req_cmd(req_cmd), .req_bank(req_bank), .req_addr(req_addr), .req_wdata(8'h5A),
    .banks_idle(banks_idle), .odt_want(odt_want), .req_ready(req_ready), .link(link_if));
  mode_set_mem mode_set_mem_inst (.clk(clk), .rst(rst), .link(link_if),
    .base_mode_register(base_mode_register), .settings_ready(settings_ready),
    .dll_reset_pulse(dll_reset_pulse), .col_addr(col_addr), .col_write(col_write),
    .col_wdata(col_wdata));
  mode_set_props mode_set_props_inst (.clk(clk), .rst(rst), .cmd(link_if.cmd),
    .bank(link_if.bank), .addr(link_if.addr), .cke(link_if.cke), .odt(link_if.odt),
    .rvalid(link_if.rvalid), .rdrive(link_if.rdrive), .rcol(link_if.rcol));
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk)
  begin
    if (link_if.rvalid)
      rq.push_back(link_if.rcol);
    if (col_write)
    begin
      wq.push_back(col_addr);
      dq.push_back(col_wdata);
    end
    if (dll_reset_pulse)
      dll_seen++;
  end
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Waits out refusals; the lock wait after a DLL reset is the longest
  task automatic send(input mode_set_pkg::cmd_e c, input logic [2:0] b, input logic [17:0] a);
    int n;
    @(negedge clk);
    {req_valid, req_cmd, req_bank, req_addr} = {1'b1, c, b, a};
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (req_ready !== 1'b1 && n < 700);
    if (n == 700)
      err_count++;
    @(negedge clk);
    req_valid = 1'b0;
  endtask
  task automatic mrs(input logic [2:0] b, input logic [17:0] a);
    int n;
    n = wq.size();
    send(mode_set_pkg::cmd_mrs, b, a);
    repeat (12) @(posedge clk);
    #1 chk(18'(settings_ready), 18'h0);
    @(posedge clk);
    #1 chk(18'(settings_ready), 18'h1);
    chk(18'(wq.size()), 18'(n));
    if (b == `BANK_SEL_MR0)
      chk(base_mode_register, a & ~`BMR_RSVD_MASK & ~18'h00100);
  endtask
  task automatic burst(input logic wr, input logic [2:0] s);
    int j;
    rq.delete();
    wq.delete();
    dq.delete();
    send(wr ? mode_set_pkg::cmd_write : mode_set_pkg::cmd_read, 3'h0,
      {5'h00, k[0], 2'h0, 7'h2A, s});
    repeat (16) @(posedge clk);
    chk(18'(wr ? wq.size() : rq.size()), c4 ? 18'h4 : 18'h8);
    for (j = 0; j < (c4 ? 4 : 8); j++)
      if (wr)
      begin
        chk(18'(wq[j]), {8'h0, 7'h2A, c4 ? {s[2], 2'(j)} : 3'(j)});
        chk(18'(dq[j]), 18'(8'h5A + 8'(j)));
      end
      else
        chk(18'(rq[j]), 18'(t ? s ^ 3'(j) : {s[2] ^ (j >= 4), s[1:0] + 2'(j)}));
  endtask
  initial
  begin
    {rst, req_valid, banks_idle, odt_want, req_cmd, req_bank, req_addr} = 0;
    rst = 1'b1;
    repeat (4) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    odt_want = 1'b1;
    req_valid = 1'b1;
    req_cmd = mode_set_pkg::cmd_mrs;
    @(negedge clk);
    chk(18'(req_ready), 18'h0);
    {banks_idle, req_valid} = 2'b10;
    mrs(`BANK_SEL_MR2, 18'h00008);
    send(mode_set_pkg::cmd_long_impedance_calibration, 3'h0, 18'h00000);
    for (t = 0; t < 2; t++)
      for (m = 0; m < 3; m++)
      begin
        code = m == 0 ? `BL_CODE_FIXED8 : m == 1 ? `BL_CODE_CHOP4 : `BL_CODE_OTF;
        mrs(`BANK_SEL_MR0, {9'h000, t == 0 && m == 0, 4'h8, t[0], 1'b0, code});
        for (k = 0; k < 4; k++)
        begin
          c4 = m == 1 || (m == 2 && !k[0]);
          burst(1'b0, 3'(k * 3 + 1));
          burst(1'b1, 3'(k * 3 + 5));
        end
        $display("test type %0d length code %0d done", t, code);
      end
    chk(18'(dll_seen), 18'h1);
    give_verdict();
  end
  initial
  begin
    #500000;
    err_count++;
    give_verdict();
  end
endmodule
